// File: dcc_crc_cells.sv
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// - Writing the checksum value register seeds the running checksum.
// - Reading the checksum value register returns the present result.
// - Control bit 15 selects IP header mode when one, LFSR when zero.
// - In LFSR mode value bits above poly length read as zero.
// - In IP header mode upper 16 value bits always read zero.
// - In IP header mode value reads back in one's complement form.
// - Tap mask one enables XOR feedback into that stage; zero shifts directly.
// - In IP header mode the tap mask is ignored.
// - Cell length field gives bytes moved per event; all ones means 65,535.
// - Cell length bits 31 to 16 are unimplemented and read zero.
// - Cell progress is a read-only 16-bit count, reset zero, upper bits zero.
// - In pattern detect mode a pattern match clears the cell progress.
module dcc_crc_cells
    import dcc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire dcc_beat_type dma_beat,
    input wire logic pattern_match,
    output logic cell_done
);

    // =====================================================
    // Registers
    logic [15:0] crc_control_reg_r;
    logic [31:0] crc_value_r;
    logic [31:0] crc_value_nxt;
    logic [31:0] crc_feedback_tap_mask_r;
    logic [15:0] cell_byte_count_r;
    logic [15:0] cell_progress_count_r;
    logic [15:0] cell_progress_count_nxt;
    logic [31:0] reg_rdata_r;
    logic cell_done_r;
    logic cell_done_nxt;

    dcc_kind_type kind;
    logic engine_en;
    logic pat_mode;
    logic [DCC_POLY_LENGTH_W-1:0] poly_length;
    logic [31:0] poly_length_mask;
    logic [31:0] value_view;

    logic wr_ctrl;
    logic wr_value;
    logic wr_taps;
    logic wr_cell_len;

    // =====================================================
    // Address decode
    // Unmapped indices decode to nothing, so writes there are dropped
    always_comb begin
        wr_ctrl = 1'b0;
        wr_value = 1'b0;
        wr_taps = 1'b0;
        wr_cell_len = 1'b0;
        if (reg_wr && reg_addr == DCC_IDX_CTRL) begin
            wr_ctrl = 1'b1;
        end else if (reg_wr && reg_addr == DCC_IDX_VALUE) begin
            wr_value = 1'b1;
        end else if (reg_wr && reg_addr == DCC_IDX_TAPS) begin
            wr_taps = 1'b1;
        end else if (reg_wr && reg_addr == DCC_IDX_CELL_LEN) begin
            wr_cell_len = 1'b1;
        end
    end

    // =====================================================
    // Control fields
    // kind bit select
    assign kind = crc_control_reg_r[DCC_CTRL_KIND_POS] ? DCC_KIND_IPHDR : DCC_KIND_LFSR;
    assign engine_en = crc_control_reg_r[DCC_CTRL_EN_POS];
    assign pat_mode = crc_control_reg_r[DCC_CTRL_PAT_POS];
    assign poly_length = crc_control_reg_r[DCC_CTRL_POLY_LENGTH_LSB +: DCC_POLY_LENGTH_W];

    // =====================================================
    // Software written registers
    // Only the low half of the control word is implemented
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            crc_control_reg_r <= 16'h0000;
        end else if (wr_ctrl) begin
            crc_control_reg_r <= reg_wdata[15:0];
        end
    end

    // Kept in both modes; only the LFSR chain reads it
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            crc_feedback_tap_mask_r <= DCC_TAPS_RST;
        end else if (wr_taps) begin
            crc_feedback_tap_mask_r <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cell_byte_count_r <= DCC_CELL_LEN_RST;
        end else if (wr_cell_len) begin
            cell_byte_count_r <= reg_wdata[15:0];
        end
    end

    // =====================================================
    // Checksum engine
    logic [31:0] lfsr_s1;
    logic [31:0] lfsr_s2;
    logic [31:0] lfsr_s3;
    logic [31:0] lfsr_s4;
    logic [15:0] ip_s1;
    logic [15:0] ip_s2;
    logic [15:0] ip_acc;

    // =====================================================
    // LFSR byte chain
    // Byte lanes beyond the beat size are skipped below
    dcc_lfsr_step u_step0 (
        .state(crc_value_r),
        .taps(crc_feedback_tap_mask_r),
        .poly_length(poly_length),
        .data_byte(dma_beat.data[7:0]),
        .next_state(lfsr_s1)
    );

    dcc_lfsr_step u_step1 (
        .state(lfsr_s1),
        .taps(crc_feedback_tap_mask_r),
        .poly_length(poly_length),
        .data_byte(dma_beat.data[15:8]),
        .next_state(lfsr_s2)
    );

    dcc_lfsr_step u_step2 (
        .state(lfsr_s2),
        .taps(crc_feedback_tap_mask_r),
        .poly_length(poly_length),
        .data_byte(dma_beat.data[23:16]),
        .next_state(lfsr_s3)
    );

    dcc_lfsr_step u_step3 (
        .state(lfsr_s3),
        .taps(crc_feedback_tap_mask_r),
        .poly_length(poly_length),
        .data_byte(dma_beat.data[31:24]),
        .next_state(lfsr_s4)
    );

    // =====================================================
    // IP header word sum
    // IP sum keeps the running sum; the read shows its complement
    assign ip_acc = crc_value_r[15:0];
    dcc_ones_sum u_sum0 (
        .acc(ip_acc),
        .word(dma_beat.data[15:0]),
        .sum(ip_s1)
    );

    dcc_ones_sum u_sum1 (
        .acc(ip_s1),
        .word(dma_beat.data[31:16]),
        .sum(ip_s2)
    );

    // =====================================================
    // Next checksum value
    logic beat_take;
    logic ip_two_words;
    logic [31:0] lfsr_pick;
    logic [15:0] ip_pick;

    // Only an enabled engine consumes beats; the checksum ignores others, but cell progress still counts them
    assign beat_take = engine_en && dma_beat.valid;
    assign ip_two_words = dma_beat.nbytes_m1 == 2'h3;

    // Beat size decides where the byte chain is tapped
    always_comb begin
        case (dma_beat.nbytes_m1)
            2'h0: lfsr_pick = lfsr_s1;
            2'h1: lfsr_pick = lfsr_s2;
            2'h2: lfsr_pick = lfsr_s3;
            default: lfsr_pick = lfsr_s4;
        endcase
    end

    // Upper word joins the sum only for a full four-byte beat
    always_comb begin
        if (ip_two_words) begin
            ip_pick = ip_s2;
        end else begin
            ip_pick = ip_s1;
        end
    end

    // Value write and beat in one cycle: the write wins
    always_comb begin
        crc_value_nxt = crc_value_r;
        if (wr_value) begin
            if (kind == DCC_KIND_IPHDR) begin
                crc_value_nxt = {16'h0000, ~reg_wdata[15:0]};
            end else begin
                crc_value_nxt = reg_wdata;
            end
        end else if (beat_take) begin
            if (kind == DCC_KIND_IPHDR) begin
                crc_value_nxt = {16'h0000, ip_pick};
            end else begin
                crc_value_nxt = lfsr_pick;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            crc_value_r <= DCC_VALUE_RST;
        end else begin
            crc_value_r <= crc_value_nxt;
        end
    end

    // =====================================================
    // Value register view
    // Built bit by bit so every length from 1 to 32 bits works
    always_comb begin
        poly_length_mask = 32'hFFFF_FFFF;
        for (int i = 0; i < 32; i++) begin
            poly_length_mask[i] = (i <= int'(poly_length));
        end
    end

    logic [31:0] ip_view;
    logic [31:0] lfsr_view;

    assign ip_view = {16'h0000, ~crc_value_r[15:0]};
    assign lfsr_view = crc_value_r & poly_length_mask;

    always_comb begin
        if (kind == DCC_KIND_IPHDR) begin
            value_view = ip_view;
        end else begin
            value_view = lfsr_view;
        end
    end

    // =====================================================
    // Cell progress
    logic [16:0] prog_sum;
    logic [16:0] byte_step;
    logic match_clear;
    logic cell_full;

    assign byte_step = {15'h0000, dma_beat.nbytes_m1} + 17'h00001;
    assign prog_sum = {1'b0, cell_progress_count_r} + byte_step;
    // Seventeen bits, so a beat stepping past 65,535 still ends the cell
    assign cell_full = prog_sum >= {1'b0, cell_byte_count_r};
    assign match_clear = pat_mode && pattern_match;

    // A match outranks a beat arriving in the same cycle
    always_comb begin
        cell_progress_count_nxt = cell_progress_count_r;
        cell_done_nxt = 1'b0;
        if (match_clear) begin
            cell_progress_count_nxt = DCC_CELL_PROG_RST;
        end else if (dma_beat.valid) begin
            if (cell_full) begin
                cell_progress_count_nxt = DCC_CELL_PROG_RST;
                cell_done_nxt = 1'b1;
            end else begin
                cell_progress_count_nxt = prog_sum[15:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cell_progress_count_r <= DCC_CELL_PROG_RST;
        end else begin
            cell_progress_count_r <= cell_progress_count_nxt;
        end
    end

    // Registered so the channel sees a clean one-cycle pulse
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cell_done_r <= 1'h0;
        end else begin
            cell_done_r <= cell_done_nxt;
        end
    end

    assign cell_done = cell_done_r;

    // =====================================================
    // Read port, data one cycle after strobe
    logic [31:0] rd_view;

    // Decoded ahead of the flop so one edge carries the answer
    always_comb begin
        rd_view = DCC_UNMAPPED_READ;
        if (reg_addr == DCC_IDX_CTRL) begin
            rd_view = {16'h0000, crc_control_reg_r};
        end else if (reg_addr == DCC_IDX_VALUE) begin
            rd_view = value_view;
        end else if (reg_addr == DCC_IDX_TAPS) begin
            rd_view = crc_feedback_tap_mask_r;
        end else if (reg_addr == DCC_IDX_CELL_LEN) begin
            rd_view = {16'h0000, cell_byte_count_r};
        end else if (reg_addr == DCC_IDX_CELL_PROG) begin
            rd_view = {16'h0000, cell_progress_count_r};
        end
    end

    // Bus idles at zero so a stray sample never shows old data
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            reg_rdata_r <= DCC_UNMAPPED_READ;
        end else if (reg_rd) begin
            reg_rdata_r <= rd_view;
        end else begin
            reg_rdata_r <= DCC_UNMAPPED_READ;
        end
    end

    assign reg_rdata = reg_rdata_r;

endmodule

// File: dcc_pkg.sv
package dcc_pkg;

    // =====================================================
    // Register indices (byte address = index * 4)
    localparam logic [3:0] DCC_IDX_CTRL = 4'h0;
    localparam logic [3:0] DCC_IDX_VALUE = 4'h1;
    localparam logic [3:0] DCC_IDX_TAPS = 4'h2;
    localparam logic [3:0] DCC_IDX_CELL_LEN = 4'h3;
    localparam logic [3:0] DCC_IDX_CELL_PROG = 4'h4;

    // =====================================================
    // Control register fields
    localparam int DCC_CTRL_KIND_POS = 15;
    localparam int DCC_CTRL_EN_POS = 7;
    localparam int DCC_CTRL_PAT_POS = 6;
    localparam int DCC_CTRL_POLY_LENGTH_LSB = 0;
    localparam int DCC_POLY_LENGTH_W = 5;

    // =====================================================
    // Reset values
    localparam logic [31:0] DCC_VALUE_RST = 32'h0000_0000;
    localparam logic [31:0] DCC_TAPS_RST = 32'h0000_0000;
    localparam logic [15:0] DCC_CELL_LEN_RST = 16'h0000;
    localparam logic [15:0] DCC_CELL_PROG_RST = 16'h0000;
    localparam logic [31:0] DCC_UNMAPPED_READ = 32'h0000_0000;

    typedef enum logic [1:0] {
        DCC_KIND_LFSR = 2'b01,
        DCC_KIND_IPHDR = 2'b10
    } dcc_kind_type;

    // Data beat from the DMA channel
    typedef struct packed {
        logic valid;
        logic [1:0] nbytes_m1;
        logic [31:0] data;
    } dcc_beat_type;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } dcc_bus_req_type;

endpackage

// File: dcc_lfsr_step.sv
`timescale 1ns/1ps
module dcc_lfsr_step
    import dcc_pkg::*;
(
    input wire logic [31:0] state,
    input wire logic [31:0] taps,
    input wire logic [DCC_POLY_LENGTH_W-1:0] poly_length,
    input wire logic [7:0] data_byte,
    output logic [31:0] next_state
);
    logic [31:0] s;
    logic fb;
    always_comb begin
        s = state;
        fb = 1'b0;
        for (int b = 0; b < 8; b++) begin
            fb = s[poly_length] ^ data_byte[b];
            for (int k = 31; k > 0; k--) begin
                s[k] = s[k-1] ^ (taps[k] & fb);
            end
            s[0] = fb;
        end
        next_state = s;
    end
endmodule

// File: dcc_ones_sum.sv
`timescale 1ns/1ps
module dcc_ones_sum (
    input wire logic [15:0] acc,
    input wire logic [15:0] word,
    output logic [15:0] sum
);
    logic [16:0] raw;
    always_comb begin
        raw = {1'b0, acc} + {1'b0, word};
        sum = raw[15:0] + {15'h0000, raw[16]};
    end
endmodule

// File: dcc_crc_cells_chk.sv
`timescale 1ns/1ps
module dcc_crc_cells_chk
    import dcc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire dcc_beat_type dma_beat,
    input wire logic pattern_match,
    input wire logic cell_done
);
    // ========================================
    // Control shadow, kept from bus writes
    logic kind_r;
    logic pat_r;
    logic [4:0] poly_length_r;
    logic [31:0] msk;
    logic vrd;
    logic idle;
    assign msk = 32'hFFFF_FFFF >> (5'h1F - poly_length_r);
    assign vrd = reg_rd && reg_addr == DCC_IDX_VALUE;
    assign idle = !dma_beat.valid && !reg_wr;
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            kind_r <= 1'h0;
            pat_r <= 1'h0;
            poly_length_r <= 5'h0;
        end else if (reg_wr && reg_addr == DCC_IDX_CTRL) begin
            kind_r <= reg_wdata[DCC_CTRL_KIND_POS];
            pat_r <= reg_wdata[DCC_CTRL_PAT_POS];
            poly_length_r <= reg_wdata[DCC_POLY_LENGTH_W-1:0];
        end
    end
    // ========================================
    // Properties
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    sequence s_seed;
        reg_wr && reg_addr == DCC_IDX_VALUE ##1 idle ##1 vrd && idle;
    endsequence
    sequence s_clear;
        pattern_match && pat_r ##1 idle ##1 reg_rd && reg_addr == DCC_IDX_CELL_PROG && idle;
    endsequence
    sequence s_two_reads;
        vrd && idle ##1 idle ##1 vrd && idle;
    endsequence
    a_rd_idle_zero: assert property (
        !reg_rd |=> reg_rdata == 32'h0) else $error("read data outside answer");
    a_len_upper_zero: assert property (
        reg_rd && reg_addr == DCC_IDX_CELL_LEN |=> reg_rdata[31:16] == 16'h0)
        else $error("cell length upper bits set");
    a_prog_upper_zero: assert property (
        reg_rd && reg_addr == DCC_IDX_CELL_PROG |=> reg_rdata[31:16] == 16'h0)
        else $error("progress upper bits set");
    a_ip_upper_zero: assert property (
        vrd && kind_r |=> reg_rdata[31:16] == 16'h0) else $error("ip upper bits set");
    a_lfsr_len_mask: assert property (
        vrd && !kind_r |=> (reg_rdata & ~$past(msk)) == 32'h0)
        else $error("bits above length set");
    a_lfsr_seed_back: assert property (
        !kind_r ##0 s_seed |=> reg_rdata == ($past(reg_wdata, 3) & $past(msk)))
        else $error("seed not read back");
    a_ip_seed_back: assert property (
        kind_r ##0 s_seed |=> reg_rdata == {16'h0, $past(reg_wdata[15:0], 3)})
        else $error("ip seed not read back");
    a_match_clears: assert property (
        s_clear |=> reg_rdata == 32'h0) else $error("progress not cleared");
    a_value_holds: assert property (
        s_two_reads |=> reg_rdata == $past(reg_rdata, 2)) else $error("value moved");
    a_done_after_beat: assert property (
        cell_done |-> $past(dma_beat.valid)) else $error("done without beat");
endmodule

bind dcc_crc_cells dcc_crc_cells_chk i_chk (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .dma_beat(dma_beat),
    .pattern_match(pattern_match),
    .cell_done(cell_done)
);

// File: dcc_dma_model.sv
`timescale 1ns/1ps
module dcc_dma_model
    import dcc_pkg::*;
(
    input wire logic sys_clk,
    output dcc_beat_type dma_beat
);
    initial dma_beat = '0;
    // ========================================
    // One beat per call; the idle cycle after it carries inverted data so stale bytes show
    task automatic send(input logic [31:0] d, input logic [1:0] n, input int gap);
        repeat (gap) @(posedge sys_clk);
        @(posedge sys_clk);
        dma_beat <= '{1'h1, n, d};
        @(posedge sys_clk);
        dma_beat <= '{1'h0, n, ~d};
    endtask
endmodule

// File: dcc_crc_cells_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module dcc_crc_cells_tb
    import dcc_pkg::*;
;
    typedef struct packed {
        logic [3:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } dcc_row_type;
    dcc_row_type rows [5] = '{'{DCC_IDX_TAPS, 32'hFFFF_FFFF, 32'hFFFF_FFFF},
        '{DCC_IDX_CELL_LEN, 32'hFFFF_FFFF, 32'h0000_FFFF},
        '{DCC_IDX_CELL_PROG, 32'h0000_1234, 32'h0},
        '{DCC_IDX_VALUE, 32'hA5A5_5A5A, 32'hA5A5_5A5A},
        '{4'hF, 32'h1234_5678, 32'h0}};
    logic [4:0] pl [3] = '{5'h1F, 5'h0F, 5'h07};
    logic [31:0] tp [3] = '{32'h04C1_1DB7, 32'h0000_1021, 32'h0000_0007};
    logic sys_clk = 1'h0;
    logic nrst = 1'h0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic pattern_match = 1'h0;
    logic [31:0] reg_rdata;
    logic cell_done;
    dcc_beat_type dma_beat;
    logic [31:0] e;
    logic [15:0] s;
    int n_mismatch = 0;
    int n_checks = 0;
    always #25 sys_clk = ~sys_clk;
    dcc_crc_cells i_dut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .dma_beat(dma_beat), .pattern_match(pattern_match), .cell_done(cell_done));
    dcc_dma_model i_dma (.sys_clk(sys_clk), .dma_beat(dma_beat));
    // ========================================
    // Bus tasks and reference sums
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge sys_clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rc(input logic [3:0] a, input logic [31:0] x);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge sys_clk);
        reg_rd <= 1'h0;
        #1;
        `CHK(reg_rdata, x)
    endtask
    task automatic pm;
        @(posedge sys_clk);
        pattern_match <= 1'h1;
        @(posedge sys_clk);
        pattern_match <= 1'h0;
    endtask
    function automatic logic [31:0] lfsr(logic [31:0] v, logic [31:0] t, logic [4:0] p,
        logic [31:0] d, int nb);
        logic fb;
        for (int i = 0; i < nb * 8; i++) begin
            fb = v[p] ^ d[i];
            v = (v << 1) ^ (t & {32{fb}});
            v[0] = fb;
        end
        return v;
    endfunction
    function automatic logic [15:0] osum(logic [15:0] a, logic [15:0] b);
        logic [16:0] t;
        t = {1'h0, a} + {1'h0, b};
        return t[15:0] + {15'h0, t[16]};
    endfunction
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #100000;
        n_mismatch++;
        finish_test;
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        nrst <= 1'h1;
        for (int i = 0; i < 5; i++) rc(4'(i), 32'h0);
        $display("end reset");
        wr(DCC_IDX_CTRL, 32'h0000_001F);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rc(rows[i].a, rows[i].e);
        end
        $display("end rows");
        foreach (pl[i]) begin
            wr(DCC_IDX_CTRL, {24'h0, 3'h4, pl[i]});
            wr(DCC_IDX_TAPS, tp[i]);
            wr(DCC_IDX_VALUE, 32'hFFFF_FFFF);
            i_dma.send(32'h1234_5678, 2'h3, 0);
            i_dma.send(32'h00BC_DE9A, 2'(i), 2);
            e = lfsr(lfsr(32'hFFFF_FFFF, tp[i], pl[i], 32'h1234_5678, 4), tp[i], pl[i],
                32'h00BC_DE9A, i + 1) & (32'hFFFF_FFFF >> (5'h1F - pl[i]));
            rc(DCC_IDX_VALUE, e);
        end
        wr(DCC_IDX_CTRL, 32'h0000_0007);
        i_dma.send(32'hDEAD_BEEF, 2'h3, 0);
        rc(DCC_IDX_VALUE, e);
        rc(DCC_IDX_VALUE, e);
        $display("end lfsr");
        wr(DCC_IDX_CTRL, 32'h0000_8080);
        wr(DCC_IDX_TAPS, 32'hFFFF_FFFF);
        wr(DCC_IDX_VALUE, 32'hFFFF_1234);
        rc(DCC_IDX_VALUE, 32'h0000_1234);
        i_dma.send(32'h0001_F203, 2'h3, 0);
        i_dma.send(32'h5555_00F0, 2'h1, 0);
        s = osum(osum(osum(~16'h1234, 16'hF203), 16'h0001), 16'h00F0);
        rc(DCC_IDX_VALUE, {16'h0, ~s});
        $display("end ip");
        pm();
        rc(DCC_IDX_CELL_PROG, 32'h0000_001C);
        wr(DCC_IDX_CTRL, 32'h0000_0040);
        pm();
        rc(DCC_IDX_CELL_PROG, 32'h0);
        wr(DCC_IDX_CELL_LEN, 32'h0000_0006);
        i_dma.send(32'h0, 2'h3, 0);
        #1;
        `CHK(cell_done, 1'h0)
        rc(DCC_IDX_CELL_PROG, 32'h0000_0004);
        i_dma.send(32'h0, 2'h1, 0);
        #1;
        `CHK(cell_done, 1'h1)
        rc(DCC_IDX_CELL_PROG, 32'h0);
        i_dma.send(32'h0, 2'h0, 0);
        pm();
        rc(DCC_IDX_CELL_PROG, 32'h0);
        $display("end cells");
        wr(DCC_IDX_VALUE, 32'h0000_00FF);
        @(posedge sys_clk);
        nrst <= 1'h0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'h1;
        #1;
        `CHK(cell_done, 1'h0)
        for (int i = 0; i < 5; i++) rc(4'(i), 32'h0);
        $display("end mid reset");
        finish_test;
    end
endmodule
